// *** hdl/rscc_course_ctrl.sv ***
// Heading-hold rudder servo: set course, course error, rudder demand, drive outputs.
// Assumes heading, navigation course, gain and feedback codes come from same-clock logic.
`timescale 1ns/1ps
`include "rscc_defines.svh"

module rscc_course_ctrl
  import rscc_pkg::*;
#(
  parameter int unsigned SYNTH_STEP_CYC = (`RSCC_SYNTH_STEP_US * 1000) / `RSCC_CLK_PERIOD_NS,
  parameter int unsigned FB_TIMEOUT_CYC = (`RSCC_FB_TIMEOUT_US * 1000) / `RSCC_CLK_PERIOD_NS
)
(
  // Clock and reset
  input  wire logic          ref_clk_in,
  input  wire logic          arst_n_in,
  // Course selector and mode pins
  input  wire logic          sel_a_in,
  input  wire logic          sel_b_in,
  input  wire logic          auto_sel_in,
  input  wire logic          nav_sel_in,
  // Compass heading and navigation module course
  input  wire rscc_course_t  heading_in,
  input  wire rscc_course_t  nav_course_in,
  // Gain setting and rudder feedback converter
  input  wire logic [7:0]    rudder_gain_pot_in,
  input  wire rscc_adc_t     heading_feedback_adc_in,
  // Steering drives
  output logic               starboard_drive_out,
  output logic               port_drive_out,
  // Status
  output logic [8:0]         set_course_out,
  output logic signed [9:0]  course_error_out,
  output logic signed [10:0] rudder_demand_out,
  output logic               fb_lost_out
);

  rscc_regs_t         q;
  rscc_regs_t         n;
  logic               sel_step;
  logic               sel_up;
  logic               engaged;
  logic               fb_bad;
  logic signed [10:0] pos;

  ////////////////////////////////////////////////////////////////////////
  rscc_selector_dec u_dec (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .sel_a_in   (sel_a_in),
    .sel_b_in   (sel_b_in),
    .step_out   (sel_step),
    .up_out     (sel_up)
  );

  assign engaged = q.auto_s[1] | q.nav_s[1];
  assign fb_bad  = (heading_feedback_adc_in.code < `RSCC_FB_CODE_MIN) ||
                   (heading_feedback_adc_in.code > `RSCC_FB_CODE_MAX);
  assign pos     = q.fb_lost ? q.syn_pos : q.fb_pos;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = q;
    n.auto_s = {q.auto_s[0], auto_sel_in};
    n.nav_s  = {q.nav_s[0], nav_sel_in};

    if (heading_in.valid)
      n.hdg = heading_in.deg;

    // Set course: standby tracks heading so engaging keeps the present course
    if (!engaged)
      n.set_crs = q.hdg;
    else begin
      if (sel_step)
        n.set_crs = rscc_step_course(q.set_crs, sel_up);
      if (q.nav_s[1] && nav_course_in.valid)
        n.set_crs = nav_course_in.deg;
    end

    if (heading_feedback_adc_in.valid) begin
      n.tmo = `RSCC_CNT_ZERO;
      if (fb_bad)
        n.fb_lost = 1'b1;
      else
        n.fb_pos = $signed({1'b0, heading_feedback_adc_in.code}) - `RSCC_FB_CODE_MID;
    end else if (q.tmo == 20'(FB_TIMEOUT_CYC - 1))
      n.fb_lost = 1'b1;
    else
      n.tmo = q.tmo + `RSCC_CNT_ONE;

    // synthesized model starts from last good feedback
    if (!q.fb_lost)
      n.syn_pos = q.fb_pos;
    // fixed rudder speed, one count per step time
    else if (q.stbd || q.port) begin
      if (q.stp == 20'(SYNTH_STEP_CYC - 1)) begin
        n.stp     = `RSCC_CNT_ZERO;
        n.syn_pos = q.stbd ? q.syn_pos + `RSCC_POS_ONE : q.syn_pos - `RSCC_POS_ONE;
      end else
        n.stp = q.stp + `RSCC_CNT_ONE;
    end else
      n.stp = `RSCC_CNT_ZERO;

    case (q.st)
      ST_COMPUTE: begin
        n.gain = rudder_gain_pot_in;
        n.dem  = rscc_size_demand(q.err, rudder_gain_pot_in);
        n.st   = engaged ? ST_STEER : ST_STANDBY;
      end
      ST_STANDBY, ST_STEER: begin
        if (!engaged) begin
          n.st  = ST_STANDBY;
          n.dem = '0;
        end else if (heading_in.valid) begin
          n.err = rscc_course_err(q.set_crs, heading_in.deg);
          n.st  = ST_COMPUTE;
        end
      end
      default: n.st = ST_STANDBY;
    endcase

    // drive toward demand, release when equal, synthesized too
    // two drives, strict compare keeps them exclusive
    n.stbd = engaged && (q.st != ST_STANDBY) && (pos < q.dem);
    n.port = engaged && (q.st != ST_STANDBY) && (pos > q.dem);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      q <= '0;
    else
      q <= n;
  end

  // drives go straight to the junction unit
  assign starboard_drive_out = q.stbd;
  assign port_drive_out      = q.port;
  assign set_course_out      = q.set_crs;
  assign course_error_out    = q.err;
  assign rudder_demand_out   = q.dem;
  assign fb_lost_out         = q.fb_lost;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_hdg_taken;
    engaged && heading_in.valid && (q.st != ST_COMPUTE);
  endsequence

  sequence s_computed;
    (q.st == ST_COMPUTE) ##1 (q.st == ST_STEER);
  endsequence

  drive_exclusive_a: assert property (!(q.stbd && q.port))
    else $error("Both drives on");

  sel_step_up_a: assert property (
    q.auto_s[1] && !q.nav_s[1] && sel_step && sel_up && q.set_crs != `RSCC_DEG_LAST
    |=> q.set_crs == $past(q.set_crs) + `RSCC_DEG_ONE)
    else $error("Selector up step not one degree");

  sel_step_down_a: assert property (
    q.auto_s[1] && !q.nav_s[1] && sel_step && !sel_up && q.set_crs != `RSCC_DEG_ZERO
    |=> q.set_crs == $past(q.set_crs) - `RSCC_DEG_ONE)
    else $error("Selector down step wrong");

  course_wrap_a: assert property (
    q.auto_s[1] && !q.nav_s[1] && sel_step && sel_up && q.set_crs == `RSCC_DEG_LAST
    |=> q.set_crs == `RSCC_DEG_ZERO)
    else $error("Set course did not wrap");

  error_calc_a: assert property (s_hdg_taken |=> s_computed and
    (q.err == rscc_course_err($past(q.set_crs), $past(heading_in.deg))))
    else $error("Course error not computed from heading");

  gain_sample_a: assert property (engaged && q.st == ST_COMPUTE
    |=> q.gain == $past(rudder_gain_pot_in) && q.dem == rscc_size_demand($past(q.err), q.gain))
    else $error("Demand not built from sampled gain");

  nav_load_a: assert property (q.nav_s[1] && nav_course_in.valid
    |=> q.set_crs == $past(nav_course_in.deg))
    else $error("Navigation course not loaded");

  drive_release_a: assert property (pos == q.dem |=> !q.stbd && !q.port)
    else $error("Drive on at demanded angle");

  drive_toward_a: assert property (engaged && q.st == ST_STEER && pos < q.dem
    ##1 engaged |-> q.stbd && !q.port)
    else $error("Starboard drive missing");

  fb_loss_a: assert property (heading_feedback_adc_in.valid && fb_bad |=> q.fb_lost[*3])
    else $error("Feedback loss not latched");

  synth_move_a: assert property (
    q.fb_lost && q.stbd && q.stp == 20'(SYNTH_STEP_CYC - 1)
    |=> q.syn_pos == $past(q.syn_pos) + `RSCC_POS_ONE)
    else $error("Synthesized rudder did not advance");

  course_wrap_down_a: assert property (
    q.auto_s[1] && !q.nav_s[1] && sel_step && !sel_up && q.set_crs == `RSCC_DEG_ZERO
    |=> q.set_crs == `RSCC_DEG_LAST)
    else $error("Set course did not wrap downward");

  err_range_a: assert property (
    1'b1
    |-> q.err <= `RSCC_HALF_TURN && q.err > -`RSCC_HALF_TURN)
    else $error("Course error outside half turn");

  dem_limit_a: assert property (
    1'b1
    |-> q.dem <= `RSCC_RUDDER_LIMIT && q.dem >= -`RSCC_RUDDER_LIMIT)
    else $error("Rudder demand beyond limit");

  disengage_clear_a: assert property (
    !engaged && q.st != ST_COMPUTE
    |=> q.dem == '0 && q.st == ST_STANDBY)
    else $error("Demand kept after disengage");

  drive_idle_a: assert property (
    !engaged
    |=> !q.stbd && !q.port)
    else $error("Drive on while disengaged");

  port_toward_a: assert property (
    engaged && q.st == ST_STEER && pos > q.dem
    |=> q.port && !q.stbd)
    else $error("Port drive missing");

  lost_sticky_a: assert property (
    q.fb_lost
    |=> q.fb_lost)
    else $error("Feedback loss cleared without reset");

  fb_timeout_a: assert property (
    !heading_feedback_adc_in.valid && q.tmo == 20'(FB_TIMEOUT_CYC - 1)
    |=> q.fb_lost)
    else $error("Feedback watchdog did not trip");

  fb_take_a: assert property (
    heading_feedback_adc_in.valid && !fb_bad
    |=> q.fb_pos == $signed({1'b0, $past(heading_feedback_adc_in.code)}) - `RSCC_FB_CODE_MID)
    else $error("Feedback position not taken");

  synth_still_a: assert property (
    q.fb_lost && !q.stbd && !q.port
    |=> q.syn_pos == $past(q.syn_pos))
    else $error("Synthesized rudder moved undriven");

  synth_back_a: assert property (
    q.fb_lost && q.port && q.stp == 20'(SYNTH_STEP_CYC - 1)
    |=> q.syn_pos == $past(q.syn_pos) - `RSCC_POS_ONE)
    else $error("Synthesized rudder did not retreat");

  gain_hold_a: assert property (
    q.st != ST_COMPUTE
    |=> q.gain == $past(q.gain))
    else $error("Gain changed outside computation");

  set_hold_a: assert property (
    engaged && !q.nav_s[1] && !sel_step
    |=> q.set_crs == $past(q.set_crs))
    else $error("Set course moved without a pulse");

  err_hold_a: assert property (
    !heading_in.valid
    |=> q.err == $past(q.err))
    else $error("Course error changed without heading");

  heading_store_a: assert property (
    heading_in.valid
    |=> q.hdg == $past(heading_in.deg))
    else $error("Heading sample not stored");

  standby_track_a: assert property (
    !engaged
    |=> q.set_crs == $past(q.hdg))
    else $error("Standby set course not tracking heading");

endmodule // rscc_course_ctrl

// *** hdl/rscc_defines.svh ***
// Constants for the rudder servo course control block.
// Assumes a 40 MHz system clock and a 10-bit rudder feedback converter.
`ifndef RSCC_DEFINES_SVH
`define RSCC_DEFINES_SVH

// Clock and timing, each time in its own unit
`define RSCC_CLK_PERIOD_NS   25
`define RSCC_SYNTH_STEP_US   1000
`define RSCC_FB_TIMEOUT_US   10000

// Compass circle
`define RSCC_DEG_LAST        9'h167
`define RSCC_DEG_ZERO        9'h000
`define RSCC_DEG_ONE         9'h001
`define RSCC_HALF_TURN       11'sh0b4
`define RSCC_FULL_TURN       11'sh168

// Rudder feedback converter codes for the valid current window
`define RSCC_FB_CODE_MIN     10'h055
`define RSCC_FB_CODE_MAX     10'h3aa
`define RSCC_FB_CODE_MID     11'sh200

// Demand sizing
`define RSCC_GAIN_SHIFT      4
`define RSCC_RUDDER_LIMIT    19'sh000c8
`define RSCC_POS_ONE         11'sh001
`define RSCC_CNT_ZERO        20'h00000
`define RSCC_CNT_ONE         20'h00001

`endif

// *** hdl/rscc_pkg.sv ***
// Types and shared arithmetic of the rudder servo course control block.
// Assumes rscc_defines.svh is on the include path.
`include "rscc_defines.svh"

package rscc_pkg;

  typedef enum logic [1:0] {ST_STANDBY, ST_COMPUTE, ST_STEER} rscc_state_t;

  typedef struct packed {
    logic       valid;
    logic [8:0] deg;
  } rscc_course_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] code;
  } rscc_adc_t;

  typedef struct packed {
    logic [1:0] a_s;
    logic [1:0] b_s;
    logic       a_d;
    logic       step;
    logic       up;
  } rscc_dec_regs_t;

  typedef struct packed {
    rscc_state_t        st;
    logic [1:0]         auto_s;
    logic [1:0]         nav_s;
    logic [8:0]         set_crs;
    logic [8:0]         hdg;
    logic signed [9:0]  err;
    logic [7:0]         gain;
    logic signed [10:0] dem;
    logic signed [10:0] fb_pos;
    logic signed [10:0] syn_pos;
    logic               fb_lost;
    logic [19:0]        tmo;
    logic [19:0]        stp;
    logic               stbd;
    logic               port;
  } rscc_regs_t;

  // One degree around the circle
  function automatic logic [8:0] rscc_step_course(logic [8:0] c, logic up);
    if (up)
      return (c == `RSCC_DEG_LAST) ? `RSCC_DEG_ZERO : c + `RSCC_DEG_ONE;
    else
      return (c == `RSCC_DEG_ZERO) ? `RSCC_DEG_LAST : c - `RSCC_DEG_ONE;
  endfunction

  // Signed shortest difference, set minus heading, in -179..180
  function automatic logic signed [9:0] rscc_course_err(logic [8:0] set_c, logic [8:0] hdg);
    logic signed [10:0] d;
    d = $signed({2'b00, set_c}) - $signed({2'b00, hdg});
    if (d > `RSCC_HALF_TURN)
      d = d - `RSCC_FULL_TURN;
    else if (d <= -`RSCC_HALF_TURN)
      d = d + `RSCC_FULL_TURN;
    return $signed(d[9:0]);
  endfunction

  // Error times gain, scaled and clamped to the rudder limit
  function automatic logic signed [10:0] rscc_size_demand(logic signed [9:0] e, logic [7:0] g);
    logic signed [18:0] p;
    p = e * $signed({1'b0, g});
    p = p >>> `RSCC_GAIN_SHIFT;
    if (p > `RSCC_RUDDER_LIMIT)
      p = `RSCC_RUDDER_LIMIT;
    else if (p < -`RSCC_RUDDER_LIMIT)
      p = -`RSCC_RUDDER_LIMIT;
    return $signed(p[10:0]);
  endfunction

endpackage

// *** hdl/rscc_selector_dec.sv ***
// Course selector wheel decoder: two photoreflector pins in, step pulse and direction out.
// Assumes the pins are asynchronous; a step is one rising edge of channel A.
`timescale 1ns/1ps

module rscc_selector_dec
  import rscc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // Photoreflector pins
  input  wire logic sel_a_in,
  input  wire logic sel_b_in,
  // Decoded step
  output logic      step_out,
  output logic      up_out
);

  rscc_dec_regs_t q;
  rscc_dec_regs_t n;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n       = q;
    n.a_s   = {q.a_s[0], sel_a_in};
    n.b_s   = {q.b_s[0], sel_b_in};
    n.a_d   = q.a_s[1];
    n.step  = q.a_s[1] & ~q.a_d;
    n.up    = ~q.b_s[1];
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      q <= '0;
    else
      q <= n;
  end

  assign step_out = q.step;
  assign up_out   = q.up;

  ////////////////////////////////////////////////////////////////////////
  sel_edge_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    q.step |-> $past(q.a_s[1]) && !$past(q.a_d))
    else $error("Step without a rising selector edge");

endmodule // rscc_selector_dec

// *** testbench/rscc_rudder_model.sv ***
// Rudder actuator model: steps one count per period while driven, reports position.
// Assumes the servo block's two drives and bench-chosen speed and fault modes.
`timescale 1ns/1ps

module rscc_rudder_model
  import rscc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Drives and bench controls
  input  wire logic       stbd_in,
  input  wire logic       port_in,
  input  wire logic       slow_in,
  input  wire logic [1:0] fault_in,
  // Feedback sample and true position
  output rscc_adc_t       fb_out,
  output int              pos_out
);
  int mv;
  int tk;

  ////////////////////////////////////////////////////////////////
  // drives taken as commands
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pos_out <= 0;
      mv      <= 0;
      tk      <= 0;
      fb_out  <= '0;
    end else begin
      tk <= (tk + 1) % 4;
      mv <= (stbd_in || port_in) ? mv + 1 : 0;
      // Slower than the loop delay, so no hunting
      if (mv >= (slow_in ? 13 : 9)) begin
        mv      <= 0;
        pos_out <= pos_out + (stbd_in ? 1 : -1);
      end
      fb_out.valid <= (tk == 0) && (fault_in != 2'h1);
      // Idle code toggles, never a stale match
      if (tk == 0)
        fb_out.code <= (fault_in == 2'h2) ? 10'h020 : 10'(pos_out + 'h200);
      else
        fb_out.code <= ~fb_out.code;
    end
  end
endmodule // rscc_rudder_model

// *** testbench/tb_rudder_servo_course_control.sv ***
// Self-checking bench for the rudder servo course control block.
// Assumes the actuator model at the drives, short synth and timeout counts.
`timescale 1ns/1ps

module tb_rudder_servo_course_control;
  import rscc_pkg::*;
  localparam int SYN = 4;
  logic              ref_clk_in = 1'b0;
  logic              arst_n_in = 1'b0;
  logic              sel_a = 1'b0;
  logic              sel_b = 1'b0;
  logic              auto_sel = 1'b0;
  logic              nav_sel = 1'b0;
  logic              slow = 1'b0;
  logic [1:0]        fault = 2'h0;
  logic [7:0]        gain = 8'h10;
  rscc_course_t      heading = '0;
  rscc_course_t      nav_crs = '0;
  rscc_adc_t         fb;
  logic              stbd;
  logic              port;
  logic              lost;
  logic [8:0]        set_c;
  logic signed [9:0] err;
  logic signed [10:0] dem;
  int                pos;
  int                err_total = 0;
  int                tests_run = 0;
  int                cyc = 0;
  int                exp_set;
  int                e;
  int                h;
  int                n;

  rscc_course_ctrl #(.SYNTH_STEP_CYC(SYN), .FB_TIMEOUT_CYC(20)) i_dut (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .sel_a_in(sel_a), .sel_b_in(sel_b),
    .auto_sel_in(auto_sel), .nav_sel_in(nav_sel), .heading_in(heading), .nav_course_in(nav_crs),
    .rudder_gain_pot_in(gain), .heading_feedback_adc_in(fb), .starboard_drive_out(stbd),
    .port_drive_out(port), .set_course_out(set_c), .course_error_out(err),
    .rudder_demand_out(dem), .fb_lost_out(lost));

  rscc_rudder_model i_rudder (
    .clk_in(ref_clk_in), .arst_n_in(arst_n_in), .stbd_in(stbd), .port_in(port),
    .slow_in(slow), .fault_in(fault), .fb_out(fb), .pos_out(pos));

  always #12.5 ref_clk_in = ~ref_clk_in;

  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #2;
  endtask

  function automatic int exp_err(input int s, input int g);
    int d;
    d = s - g;
    if (d > 180)
      d -= 360;
    else if (d <= -180)
      d += 360;
    return d;
  endfunction

  function automatic int exp_dem(input int x, input int g);
    int p;
    p = (x * g) >>> 4;
    return (p > 200) ? 200 : ((p < -200) ? -200 : p);
  endfunction

  task automatic do_reset();
    arst_n_in = 1'b0;
    auto_sel  = 1'b0;
    nav_sel   = 1'b0;
    fault     = 2'h0;
    tick(10);
    arst_n_in = 1'b1;
    tick(2);
  endtask

  task automatic hdg(input int v);
    heading = {1'b1, 9'(v)};
    tick(1);
    heading.valid = 1'b0;
    tick(2);
  endtask

  task automatic step(input logic up);
    sel_b = ~up;
    tick(1);
    sel_a = 1'b1;
    tick(4);
    sel_a = 1'b0;
    tick(4);
  endtask

  task automatic settle();
    tick(3);
    for (int k = 0; k < 9000 && (stbd || port); k++)
      tick(1);
    chk(20'(pos), 20'($signed(dem)));
  endtask

  always @(posedge ref_clk_in) begin
    cyc++;
    if (stbd === 1'b1 && port === 1'b1) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 2'h3, 2'h0);
    end
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    e = $urandom(99);
    do_reset();
    hdg(10);
    auto_sel = 1'b1;
    tick(3);
    exp_set = 10;
    for (int i = 0; i < 14; i++) begin
      step(i >= 11);
      exp_set = (i >= 11) ? (exp_set + 1) % 360 : (exp_set + 359) % 360;
      chk(20'(set_c), 20'(exp_set));
    end
    nav_sel = 1'b1;
    tick(3);
    nav_crs = {1'b1, 9'h07b};
    tick(1);
    nav_crs.valid = 1'b0;
    tick(1);
    exp_set = 123;
    chk(20'(set_c), 20'(exp_set));
    for (int i = 0; i < 5; i++) begin
      gain = (i == 1) ? 8'hff : 8'($urandom_range(0, 31));
      slow = 1'($urandom_range(0, 1));
      h = (i == 0) ? (exp_set + 180) % 360 : $urandom_range(0, 359);
      hdg(h);
      e = exp_err(exp_set, h);
      chk(20'($signed(err)), 20'(e));
      chk(20'($signed(dem)), 20'(exp_dem(e, gain)));
      settle();
    end
    for (int f = 1; f <= 2; f++) begin
      do_reset();
      auto_sel = 1'b1;
      gain = 8'h20;
      tick(3);
      hdg(0);
      settle();
      fault = 2'(f);
      tick(30);
      chk(20'(lost), 20'h1);
      hdg(f == 1 ? 353 : 7);
      n = 0;
      e = 0;
      repeat (200) begin
        tick(1);
        n += (f == 1) ? int'(stbd) : int'(port);
        e += (f == 1) ? int'(port) : int'(stbd);
      end
      chk(20'(n >= 14 * SYN - 4 && n <= 14 * SYN + 4), 20'h1);
      chk(20'(e), 20'h0);
    end
    final_report();
  end
endmodule // tb_rudder_servo_course_control
